// [core/amc_top.sv]
/*
  Digital timing manager and protection logic of a two-channel class-D
  amplifier controller: mode sequencing, timed mute, start-up short test,
  temperature and overcurrent shutdown with timed retry, oscillator select.
  Assumes all pins are asynchronous to clk_sys; all but rstn are synchronised here;
  the fault pins are pulled up on the board/pad and may be wired together.
*/
`timescale 1ns/1ps
`include "amc_consts.svh"
module amc_top #(
  parameter int unsigned OSC_DIV = `AMC_OSC_DIV,
  parameter int unsigned MUTE_TICKS = `AMC_MUTE_TICKS,
  parameter int unsigned RETRY_TICKS = `AMC_RETRY_TICKS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // 00 standby, 01 mute, 1x on
  input wire logic [1:0] mode_sel,
  input wire logic temperature_fault_n,
  input wire logic overcurrent_fault_n,
  // {at_supply_pos, at_supply_neg} per channel, power stage disabled
  input wire logic [1:0] feedback_input_ch1,
  input wire logic [1:0] feedback_input_ch2,
  // oscillator pin held above signal_ground
  input wire logic osc_dc_above_gnd,
  input wire logic osc_ext_clk,
  output logic power_stage_on_ch1,
  output logic power_stage_on_ch2,
  output logic audio_mute,
  output logic modulator_run,
  output logic standby_active,
  output logic short_detected,
  output logic osc_ext_selected,
  output logic carrier_tick
);
  amc_pkg::amc_regs_t r;
  amc_pkg::amc_regs_t next_r;

  // interval counts are in oscillator ticks, so time scales with the clock
  localparam logic [`AMC_CNT_W-1:0] MUTE_LAST = `AMC_CNT_W'(MUTE_TICKS - 1);
  localparam logic [`AMC_CNT_W-1:0] RETRY_LAST = `AMC_CNT_W'(RETRY_TICKS - 1);
  localparam logic [`AMC_DIV_W-1:0] DIV_LAST = `AMC_DIV_W'(OSC_DIV - 1);

  logic temp_ok;
  logic oc_ok;
  logic fb_short;
  logic want_on;
  logic want_mute;
  logic ext_rise;

  // decoded views of synchronised pins only
  always_comb
  begin
    temp_ok = r.flt_s2[0];
    oc_ok = r.flt_s2[1];
    fb_short = |r.fb_s2;
    want_on = r.mode_s2[1];
    want_mute = (r.mode_s2 == `AMC_MODE_MUTE);
    ext_rise = r.osc_s2[1] & ~r.ext_clk_d;
  end

  // one next-state process for the whole block
  always_comb
  begin
    next_r = r;
    // two-flop synchronisers; first stage read only by the second
    next_r.mode_s1 = mode_sel;
    next_r.mode_s2 = r.mode_s1;
    next_r.flt_s1 = {overcurrent_fault_n, temperature_fault_n};
    next_r.flt_s2 = r.flt_s1;
    next_r.fb_s1 = {feedback_input_ch2, feedback_input_ch1};
    next_r.fb_s2 = r.fb_s1;
    next_r.osc_s1 = {osc_ext_clk, osc_dc_above_gnd};
    next_r.osc_s2 = r.osc_s1;
    next_r.ext_clk_d = r.osc_s2[1];

    // oscillator source: external edge or internal divider
    next_r.use_ext = r.osc_s2[0];
    next_r.osc_tick = 1'b0;
    if (r.use_ext)
    begin
      next_r.div = '0;
      next_r.osc_tick = ext_rise;
    end
    else if (r.div == DIV_LAST)
    begin
      next_r.div = '0;
      next_r.osc_tick = 1'b1;
    end
    else
    begin
      next_r.div = r.div + `AMC_DIV_W'(1);
    end

    // interval counter advances on oscillator ticks only
    if (r.osc_tick)
    begin
      next_r.cnt = r.cnt + `AMC_CNT_W'(1);
    end

    case (r.st)
      amc_pkg::AMC_STANDBY:
      begin
        next_r.cnt = '0;
        if (want_on || want_mute)
        begin
          next_r.st = amc_pkg::AMC_CHECK;
        end
      end
      amc_pkg::AMC_CHECK:
      begin
        // outputs tested with the stage still disabled, so no big current
        next_r.cnt = '0;
        if (!(want_on || want_mute))
        begin
          next_r.st = amc_pkg::AMC_STANDBY;
        end
        else if (!fb_short)
        begin
          next_r.st = want_on ? amc_pkg::AMC_MUTE_WAIT : amc_pkg::AMC_MUTE;
        end
      end
      amc_pkg::AMC_MUTE_WAIT:
      begin
        if (!(want_on || want_mute))
        begin
          next_r.st = amc_pkg::AMC_STANDBY;
        end
        else if (want_mute)
        begin
          next_r.st = amc_pkg::AMC_MUTE;
        end
        else if (!oc_ok)
        begin
          next_r.st = amc_pkg::AMC_OC_WAIT;
          next_r.oc_to_on = 1'b1;
          next_r.cnt = '0;
        end
        else if (r.osc_tick && r.cnt == MUTE_LAST)
        begin
          next_r.st = amc_pkg::AMC_ON;
        end
      end
      amc_pkg::AMC_ON,
      amc_pkg::AMC_MUTE:
      begin
        next_r.cnt = '0;
        if (!(want_on || want_mute))
        begin
          next_r.st = amc_pkg::AMC_STANDBY;
        end
        else if (!oc_ok)
        begin
          next_r.st = amc_pkg::AMC_OC_WAIT;
          next_r.oc_to_on = want_on;
        end
        else if (r.st == amc_pkg::AMC_MUTE && want_on)
        begin
          next_r.st = amc_pkg::AMC_MUTE_WAIT;
        end
        else if (r.st == amc_pkg::AMC_ON && want_mute)
        begin
          next_r.st = amc_pkg::AMC_MUTE;
        end
      end
      amc_pkg::AMC_OC_WAIT:
      begin
        // stage held off; retry later, a lasting short trips again at once
        if (!(want_on || want_mute))
        begin
          next_r.st = amc_pkg::AMC_STANDBY;
        end
        else if (r.osc_tick && r.cnt == RETRY_LAST)
        begin
          next_r.cnt = '0;
          next_r.st = (r.oc_to_on && want_on) ? amc_pkg::AMC_ON : amc_pkg::AMC_MUTE;
        end
      end
      default:
      begin
        next_r.st = amc_pkg::AMC_STANDBY;
      end
    endcase

    // enables: a fault line low (wired, any stage) drops both channels
    next_r.en_ch1 = 1'b0;
    next_r.en_ch2 = 1'b0;
    if ((next_r.st == amc_pkg::AMC_ON || next_r.st == amc_pkg::AMC_MUTE ||
         next_r.st == amc_pkg::AMC_MUTE_WAIT) && oc_ok && temp_ok)
    begin
      next_r.en_ch1 = 1'b1;
      next_r.en_ch2 = 1'b1;
    end
    if (!temp_ok)
    begin
      next_r.en_ch1 = 1'b0;
      next_r.en_ch2 = 1'b0;
    end
    // temperature release needs no delay: enables follow temp_ok directly
    next_r.run_out = (next_r.st != amc_pkg::AMC_STANDBY &&
                      next_r.st != amc_pkg::AMC_CHECK) && temp_ok;
    // mute keeps the modulators switching but silences the audio
    next_r.mute_out = (next_r.st != amc_pkg::AMC_ON);
    next_r.standby_out = (next_r.st == amc_pkg::AMC_STANDBY);
    next_r.short_out = (r.st == amc_pkg::AMC_CHECK) && fb_short;
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.st <= amc_pkg::AMC_STANDBY;
      r.flt_s1 <= 2'h3;
      r.flt_s2 <= 2'h3;
      r.mute_out <= 1'b1;
      r.standby_out <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // all outputs straight from the state register
  assign power_stage_on_ch1 = r.en_ch1;
  assign power_stage_on_ch2 = r.en_ch2;
  assign audio_mute = r.mute_out;
  assign modulator_run = r.run_out;
  assign standby_active = r.standby_out;
  assign short_detected = r.short_out;
  assign osc_ext_selected = r.use_ext;
  assign carrier_tick = r.osc_tick;
endmodule

// [core/amc_consts.svh]
/*
  Constants for the amplifier mode and fault control block: mode codes,
  oscillator and interval figures.
  Assumes the system clock runs at the rate given here.
*/
// Contract
// - Mode input picks standby (low current), mute, or fully on.
// - Mute keeps channels switching but silences the audio output.
// - Requesting on first holds mute about 220 ms against pop noise.
// - One enable output per channel switches that power stage channel.
// - Temperature fault low drops both enables at once, no filtering.
// - Temperature fault released raises enables again at once.
// - Current fault low drops both enables immediately.
// - After current fault, retry every 220 ms; drop again on fault.
// - Fault inputs read high undriven; wired lines, any low shuts down.
// - Oscillator pin above ground with external clock selects it.
// - Standby to mute checks outputs for supply shorts; waits if shorted.
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH
`define AMC_SYS_CLK_MHZ 100
`define AMC_INT_OSC_KHZ 317
`define AMC_MUTE_TIME_MS 220
`define AMC_RETRY_TIME_MS 220
`define AMC_OSC_DIV ((`AMC_SYS_CLK_MHZ * 1000) / `AMC_INT_OSC_KHZ)
`define AMC_MUTE_TICKS (`AMC_MUTE_TIME_MS * `AMC_INT_OSC_KHZ)
`define AMC_RETRY_TICKS (`AMC_RETRY_TIME_MS * `AMC_INT_OSC_KHZ)
`define AMC_MODE_STANDBY 2'h0
`define AMC_MODE_MUTE 2'h1
`define AMC_CNT_W 24
`define AMC_DIV_W 16
`endif

// [core/amc_pkg.sv]
/*
  Types for the amplifier mode and fault control block.
  Assumes amc_consts.svh is on the include path.
*/
`include "amc_consts.svh"
package amc_pkg;
  typedef enum logic [2:0] {
    AMC_STANDBY = 3'h0,
    AMC_CHECK = 3'h1,
    AMC_MUTE_WAIT = 3'h2,
    AMC_ON = 3'h3,
    AMC_MUTE = 3'h4,
    AMC_OC_WAIT = 3'h5
  } amc_state_t;

  typedef struct packed {
    amc_state_t st;
    logic oc_to_on;
    logic [`AMC_CNT_W-1:0] cnt;
    logic [`AMC_DIV_W-1:0] div;
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] flt_s1;
    logic [1:0] flt_s2;
    logic [3:0] fb_s1;
    logic [3:0] fb_s2;
    logic [1:0] osc_s1;
    logic [1:0] osc_s2;
    logic ext_clk_d;
    logic use_ext;
    logic osc_tick;
    logic en_ch1;
    logic en_ch2;
    logic mute_out;
    logic run_out;
    logic standby_out;
    logic short_out;
  } amc_regs_t;
endpackage

// [dv/amc_stage_model.sv]
/*
  power stage stand-in: open-drain fault lines, output short to supply.
  assumes the bench raises hot, overload and shorted on request.
*/
`timescale 1ns/1ps
module amc_stage_model (
  input wire logic clk_sys,
  input wire logic power_stage_on_ch1,
  input wire logic power_stage_on_ch2,
  input wire logic hot,
  input wire logic overload,
  input wire logic shorted,
  output logic temperature_fault_n,
  output logic overcurrent_fault_n,
  output logic [1:0] feedback_input_ch1,
  output logic [1:0] feedback_input_ch2
);
  logic oc_pull;
  // limit trips only while switching; shutdown releases well under 1 us
  initial oc_pull = 1'b0;
  always @(negedge clk_sys)
  begin
    oc_pull <= overload && (power_stage_on_ch1 || power_stage_on_ch2);
  end
  // released open-drain lines read high through the pull-up
  assign temperature_fault_n = !hot;
  assign overcurrent_fault_n = !oc_pull;
  assign feedback_input_ch1 = {shorted, 1'b0};
  assign feedback_input_ch2 = 2'h0;
endmodule

// [dv/amc_monitor.sv]
/*
  checker on the amc_top ports: enables, mute wait, retry, short test.
  assumes 2 sync flops plus 1 output flop between pins and outputs.
*/
`timescale 1ns/1ps
module amc_monitor #(
  parameter int unsigned MUTE_TICKS = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] mode_sel,
  input wire logic temperature_fault_n,
  input wire logic overcurrent_fault_n,
  input wire logic osc_dc_above_gnd,
  input wire logic power_stage_on_ch1,
  input wire logic power_stage_on_ch2,
  input wire logic audio_mute,
  input wire logic modulator_run,
  input wire logic standby_active,
  input wire logic short_detected,
  input wire logic osc_ext_selected,
  input wire logic carrier_tick
);
  logic [23:0] mute_ticks;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ticks spent muted out of standby, the floor of the anti-pop wait
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      mute_ticks <= 24'h0;
    else if (!audio_mute || standby_active)
      mute_ticks <= 24'h0;
    else if (carrier_tick)
      mute_ticks <= mute_ticks + 24'h1;
  end
  property p_tmp_off;
    !temperature_fault_n[*4] |-> !power_stage_on_ch1 && !power_stage_on_ch2;
  endproperty
  a_tmp_off: assert property (p_tmp_off) else $error("enables up in temperature fault");
  property p_oc_off;
    !overcurrent_fault_n[*4] |-> !power_stage_on_ch1 && !power_stage_on_ch2;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("enables up in current fault");
  property p_pair;
    power_stage_on_ch1 == power_stage_on_ch2;
  endproperty
  a_pair: assert property (p_pair) else $error("channel enables differ");
  property p_standby;
    (mode_sel == 2'h0)[*4] |-> standby_active && !modulator_run && !power_stage_on_ch1;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_tmp_back;
    $rose(temperature_fault_n) ##0
      (!audio_mute && temperature_fault_n && overcurrent_fault_n && mode_sel[1])[*4]
      |-> power_stage_on_ch1;
  endproperty
  a_tmp_back: assert property (p_tmp_back) else $error("enables not restored");
  property p_unmute;
    $fell(audio_mute) |-> mute_ticks >= MUTE_TICKS - 1;
  endproperty
  a_unmute: assert property (p_unmute) else $error("mute wait too short");
  property p_retry;
    $fell(power_stage_on_ch1) ##1
      (overcurrent_fault_n && temperature_fault_n && mode_sel == 2'h2)[*8]
      |-> ##[0:100] power_stage_on_ch1;
  endproperty
  a_retry: assert property (p_retry) else $error("no restart after fault");
  property p_short;
    short_detected |-> !power_stage_on_ch1 && audio_mute && !standby_active;
  endproperty
  a_short: assert property (p_short) else $error("start-up ran on a short");
  property p_osc;
    $stable(osc_dc_above_gnd)[*4] |-> osc_ext_selected == osc_dc_above_gnd;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator select wrong");
endmodule
bind amc_top amc_monitor #(.MUTE_TICKS(MUTE_TICKS)) u_mon (.*);

// [dv/amc_top_tb.sv]
/*
  self-checking bench for amc_top: modes, faults, retry, short test, osc.
  assumes amc_stage_model beside the dut and the checker bound to it.
*/
`timescale 1ns/1ps
module amc_top_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic hot = 1'b0;
  logic overload = 1'b0;
  logic shorted = 1'b0;
  logic osc_dc_above_gnd = 1'b0;
  logic osc_ext_clk = 1'b0;
  logic temperature_fault_n, overcurrent_fault_n, osc_ext_selected, carrier_tick;
  logic power_stage_on_ch1, power_stage_on_ch2, audio_mute, modulator_run;
  logic standby_active, short_detected;
  logic [1:0] feedback_input_ch1, feedback_input_ch2;
  logic [5:0] outs;
  int mismatches = 0;
  int check_count = 0;
  int n;
  assign outs = {power_stage_on_ch1, power_stage_on_ch2, audio_mute, modulator_run,
    standby_active, short_detected};
  // short counts keep the waits to a few cycles
  amc_top #(.OSC_DIV(2), .MUTE_TICKS(4), .RETRY_TICKS(4)) i_dut (.*);
  amc_stage_model i_stage (.*);
  initial forever #5 clk_sys = !clk_sys;
  // external oscillator runs free at 7 cycles per period
  initial forever #35 osc_ext_clk = !osc_ext_clk;
  task chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task close_out;
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // bounded wait for one output bit; a hang ends the run
  task wait_bit(input int b, input logic v);
    for (n = 0; n < 300 && outs[b] !== v; n++)
      cyc(1);
    if (outs[b] !== v)
    begin
      mismatches++;
      close_out;
    end
  endtask
  task s_on;
    mode_sel = 2'h2;
    wait_bit(1, 1'b0);
    cyc(1);
    chk("mute wait", 6'h3C, outs);
    wait_bit(3, 1'b0);
    chk("on", 6'h34, outs);
  endtask
  task s_faults;
    hot = 1'b1;
    cyc(4);
    chk("hot", 6'h00, outs);
    hot = 1'b0;
    cyc(4);
    chk("cool", 6'h34, outs);
    overload = 1'b1;
    wait_bit(5, 1'b0);
    cyc(1);
    chk("oc wait", 6'h0C, outs);
    wait_bit(5, 1'b1);
    chk("retry gap", 6'h01, {5'h0, n >= 6 && n < 30});
    wait_bit(5, 1'b0);
    overload = 1'b0;
    wait_bit(5, 1'b1);
    cyc(12);
    chk("recovered", 6'h34, outs);
  endtask
  task s_mute_short;
    mode_sel = 2'h0;
    cyc(4);
    chk("standby", 6'h0A, outs);
    mode_sel = 2'h1;
    wait_bit(5, 1'b1);
    chk("mute", 6'h3C, outs);
    mode_sel = 2'h0;
    shorted = 1'b1;
    cyc(4);
    mode_sel = 2'h2;
    wait_bit(0, 1'b1);
    cyc(20);
    chk("short", 6'h09, outs);
    shorted = 1'b0;
    wait_bit(3, 1'b0);
  endtask
  task s_ext;
    osc_dc_above_gnd = 1'b1;
    mode_sel = 2'h0;
    cyc(4);
    chk("ext osc", 6'h01, {5'h0, osc_ext_selected});
    mode_sel = 2'h2;
    wait_bit(3, 1'b0);
    chk("ext mute time", 6'h01, {5'h0, n >= 21});
  endtask
  initial
  begin
    cyc(4);
    rstn = 1'b1;
    cyc(2);
    chk("reset", 6'h0A, outs);
    s_on;
    s_faults;
    s_mute_short;
    s_ext;
    close_out;
  end
endmodule
